// >>> rtl/link_cfg_pkg.sv
// Constants, register map and field layout for the serial link configuration and status slice
package link_cfg_pkg;

  // Register offsets as printed; the control register offset is locally assigned
  localparam logic [9:0] ADDR_DEVICE_IDENT = 10'h206;
  localparam logic [9:0] ADDR_FRAME_END = 10'h207;
  localparam logic [9:0] ADDR_STATUS = 10'h208;
  localparam logic [9:0] ADDR_CHAN_EN = 10'h209;
  localparam logic [9:0] ADDR_LINK_CTRL = 10'h2f0;

  // Values after reset, and the value read from unmapped offsets
  localparam logic [7:0] RST_DEVICE_IDENT = 8'h00;
  localparam logic [7:0] RST_FRAME_END = 8'h00;
  localparam logic [7:0] RST_CHAN_EN = 8'h03;
  localparam logic [7:0] RST_LINK_CTRL = 8'h00;
  localparam logic [7:0] RST_RDATA = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Link control fields
  localparam int unsigned CTRL_LINK_EN_BIT = 0;
  localparam int unsigned CTRL_8B10B_BIT = 1;

  // Frame end comma select field
  localparam int unsigned FRAME_END_SEL_LSB = 0;
  localparam int unsigned FRAME_END_SEL_MSB = 1;

  // Status fields
  localparam int unsigned ST_LINK_UP_BIT = 6;
  localparam int unsigned ST_SYNC_LEVEL_BIT = 5;
  localparam int unsigned ST_REALIGNED_BIT = 4;
  localparam int unsigned ST_PHASE_SET_BIT = 3;
  localparam int unsigned ST_SER_LOCK_BIT = 2;
  localparam int unsigned ST_CONV_LOCK_BIT = 0;

  // Channel enable fields
  localparam int unsigned CH_ONE_CHANNEL_BIT = 2;
  localparam int unsigned CH_UPPER_PAIR_BIT = 1;
  localparam int unsigned CH_LOWER_PAIR_BIT = 0;

  // Control characters, 8-bit code before 10-bit encoding
  localparam logic [7:0] K28_7_CODE = 8'hfc;
  localparam logic [7:0] K28_1_CODE = 8'h3c;
  localparam logic [7:0] K28_5_CODE = 8'hbc;

  typedef enum logic [1:0] {
    COMMA_K28_7 = 2'h0,
    COMMA_K28_1 = 2'h1,
    COMMA_K28_5 = 2'h2,
    COMMA_RSVD = 2'h3
  } comma_sel_t;

endpackage : link_cfg_pkg

// >>> rtl/frame_end_inserter.sv
// Transmit octet path: device identifier slot and opportunistic end-of-frame comma
`timescale 1ns/1ps
module frame_end_inserter
  import link_cfg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_link_8b10b,
  input wire logic [1:0] i_frame_end_sel,
  input wire logic [7:0] i_device_ident,
  input wire logic [7:0] i_octet,
  input wire logic i_octet_is_k,
  input wire logic i_frame_end_slot,
  input wire logic i_ident_slot,
  output logic [7:0] o_octet,
  output logic o_octet_is_k
);

  typedef struct packed {
    logic [7:0] octet;
    logic is_k;
  } ins_state_t;

  ins_state_t st_r;
  ins_state_t st_nxt;
  logic [7:0] comma_code;
  logic comma_valid;

  always_comb begin
    comma_code = K28_7_CODE;
    comma_valid = 1'b1;
    unique case (comma_sel_t'(i_frame_end_sel)) // RQ3
      COMMA_K28_7: comma_code = K28_7_CODE;
      COMMA_K28_1: comma_code = K28_1_CODE;
      COMMA_K28_5: comma_code = K28_5_CODE;
      COMMA_RSVD: comma_valid = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt.octet = i_octet;
    st_nxt.is_k = i_octet_is_k;
    if (i_ident_slot) begin
      st_nxt.octet = i_device_ident; // RQ1
      st_nxt.is_k = 1'b0;
    end else if (i_frame_end_slot && i_link_8b10b && comma_valid) begin
      // Other encodings carry no frame end comma, the slot passes through
      st_nxt.octet = comma_code; // RQ4
      st_nxt.is_k = 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_octet = st_r.octet;
  assign o_octet_is_k = st_r.is_k;

endmodule : frame_end_inserter

// >>> rtl/jesd_link_config_status.sv
// Register slice for link identity, frame end comma, channel pairs and link status
//
// Summary of operation
// RQ1: Device identifier register is sent in the second alignment multiframe slot.
// RQ2: Software changes identifier and comma select only with link disabled.
// RQ3: Comma select: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved; resets 0.
// RQ4: Comma inserted opportunistically, only in 8B/10B modes; no effect otherwise.
// RQ5: Software picks K28.7 for standard receivers, 1 or 2 for generic ones.
// RQ6: Status bit 6 shows link up.
// RQ7: Status bit 5 shows SYNC~ level: 0 asserted, 1 deasserted.
// RQ8: Status bit 4 sticks on any SYSREF realignment; write one clears.
// RQ9: Status bit 3 sets on first SYSREF after enable; write one clears.
// RQ10: Status bit 2 shows serializer PLL lock.
// RQ11: Status bit 0 shows converter PLL lock.
// RQ12: Software writes zero to comma select bits 7:2.
// RQ13: Channel enable resets to 0x03: one-channel 0, upper 1, lower 1.
// RQ14: One-channel mode disables channels B, C, D; lower pair stays set.
// RQ15: Software clears calibration and link enables before changing channels.
// RQ16: Pair disabled halves converters, lanes ceil(L/2), odd count pads tail.
// RQ17: Writes to live status bits are ignored.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module jesd_link_config_status
  import link_cfg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  // Register port
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Live conditions
  input wire logic i_link_up,
  input wire logic i_sync_n_pin,
  input wire logic i_ser_pll_lock,
  input wire logic i_conv_pll_lock,
  input wire logic i_sysref_realign,
  input wire logic i_sysref_event,
  // Link geometry of the selected mode with all channels on
  input wire logic [4:0] i_full_conv_count,
  input wire logic [3:0] i_full_lane_count,
  // Transmit octet stream
  input wire logic [7:0] i_tx_octet,
  input wire logic i_tx_octet_is_k,
  input wire logic i_frame_end_slot,
  input wire logic i_ident_slot,
  output logic [7:0] o_tx_octet,
  output logic o_tx_octet_is_k,
  // Configuration to the datapath
  output logic o_serial_link_enable,
  output logic o_link_8b10b,
  output logic [7:0] o_link_device_ident,
  output logic [1:0] o_frame_end_comma_select,
  output logic [3:0] o_channel_enable,
  output logic [4:0] o_conv_count,
  output logic [3:0] o_lane_count,
  output logic o_tail_pad
);

  typedef struct packed {
    logic [7:0] link_ctrl;
    logic [7:0] device_ident;
    logic [7:0] frame_end;
    logic [7:0] chan_en;
    logic realigned;
    logic phase_set;
    logic armed;
    logic link_en_d;
    logic [2:0] pin_meta;
    logic [2:0] pin_sync;
    logic [7:0] rdata;
    logic [3:0] ch_on;
    logic [4:0] conv_cnt;
    logic [3:0] lane_cnt;
    logic tail_pad;
  } cfg_state_t;

  cfg_state_t st_r;
  cfg_state_t st_nxt;

  logic wr_status;
  logic enc_start;
  logic phase_hit;
  logic one_ch;
  logic upper_on;
  logic lower_on;
  logic reduced;
  logic [7:0] status_word;
  logic [4:0] lanes_half;

  always_comb begin
    st_nxt = st_r;

    // Pins from other domains: the first stage feeds only the second
    st_nxt.pin_meta = {i_sync_n_pin, i_ser_pll_lock, i_conv_pll_lock};
    st_nxt.pin_sync = st_r.pin_meta;

    // Configuration writes; the device does not police link-enable ordering
    if (i_wr) begin
      unique case (i_addr)
        ADDR_LINK_CTRL: st_nxt.link_ctrl = i_wdata;
        ADDR_DEVICE_IDENT: st_nxt.device_ident = i_wdata; // RQ1
        ADDR_FRAME_END: st_nxt.frame_end = i_wdata; // RQ3
        ADDR_CHAN_EN: st_nxt.chan_en = i_wdata;
        default: st_nxt.link_ctrl = st_r.link_ctrl;
      endcase
    end

    // Sticky SYSREF flags: a set in the cycle of a clearing write wins
    wr_status = i_wr && (i_addr == ADDR_STATUS);
    st_nxt.realigned = i_sysref_realign ||
      (st_r.realigned && !(wr_status && i_wdata[ST_REALIGNED_BIT])); // RQ8

    enc_start = st_r.link_ctrl[CTRL_LINK_EN_BIT] && !st_r.link_en_d;
    st_nxt.link_en_d = st_r.link_ctrl[CTRL_LINK_EN_BIT];
    phase_hit = i_sysref_event && (st_r.armed || enc_start);
    // Armed from encoder start until the first SYSREF; disabling disarms
    st_nxt.armed = st_r.link_ctrl[CTRL_LINK_EN_BIT] && !phase_hit &&
      (st_r.armed || enc_start); // RQ9
    st_nxt.phase_set = phase_hit ||
      (st_r.phase_set && !(wr_status && i_wdata[ST_PHASE_SET_BIT])); // RQ9

    // Live bits come from the sources or their sync stages, so status writes cannot touch them
    status_word = 8'h00; // RQ17
    status_word[ST_LINK_UP_BIT] = i_link_up; // RQ6
    status_word[ST_SYNC_LEVEL_BIT] = st_r.pin_sync[2]; // RQ7
    status_word[ST_REALIGNED_BIT] = st_r.realigned; // RQ8
    status_word[ST_PHASE_SET_BIT] = st_r.phase_set; // RQ9
    status_word[ST_SER_LOCK_BIT] = st_r.pin_sync[1]; // RQ10
    status_word[ST_CONV_LOCK_BIT] = st_r.pin_sync[0]; // RQ11

    // Read data stands only in the cycle after the strobe
    st_nxt.rdata = RST_RDATA;
    if (i_rd) begin
      unique case (i_addr)
        ADDR_LINK_CTRL: st_nxt.rdata = st_r.link_ctrl;
        ADDR_DEVICE_IDENT: st_nxt.rdata = st_r.device_ident;
        ADDR_FRAME_END: st_nxt.rdata = st_r.frame_end;
        ADDR_STATUS: st_nxt.rdata = status_word;
        ADDR_CHAN_EN: st_nxt.rdata = st_r.chan_en;
        default: st_nxt.rdata = UNMAPPED_READ;
      endcase
    end

    // Channel enables, bit order {D, C, B, A}
    one_ch = st_r.chan_en[CH_ONE_CHANNEL_BIT];
    upper_on = st_r.chan_en[CH_UPPER_PAIR_BIT];
    lower_on = st_r.chan_en[CH_LOWER_PAIR_BIT];
    if (one_ch) begin
      // Channel A stays on even if software left the lower pair cleared
      st_nxt.ch_on = 4'h1; // RQ14
    end else begin
      st_nxt.ch_on = {upper_on, upper_on, lower_on, lower_on};
    end

    // Link geometry shrinks when a pair is off
    reduced = one_ch || !upper_on || !lower_on;
    lanes_half = ({1'b0, i_full_lane_count} + 5'h01) >> 1;
    if (reduced) begin
      st_nxt.conv_cnt = {1'b0, i_full_conv_count[4:1]}; // RQ16
      st_nxt.lane_cnt = lanes_half[3:0]; // RQ16
      st_nxt.tail_pad = i_full_lane_count[0]; // RQ16
    end else begin
      st_nxt.conv_cnt = i_full_conv_count;
      st_nxt.lane_cnt = i_full_lane_count;
      st_nxt.tail_pad = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.link_ctrl <= RST_LINK_CTRL;
      st_r.device_ident <= RST_DEVICE_IDENT;
      st_r.frame_end <= RST_FRAME_END; // RQ3
      st_r.chan_en <= RST_CHAN_EN; // RQ13
      st_r.rdata <= RST_RDATA;
      st_r.ch_on <= 4'hf;
    end else begin
      st_r <= st_nxt;
    end
  end

  frame_end_inserter u_inserter (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_link_8b10b(st_r.link_ctrl[CTRL_8B10B_BIT]),
    .i_frame_end_sel(st_r.frame_end[FRAME_END_SEL_MSB:FRAME_END_SEL_LSB]),
    .i_device_ident(st_r.device_ident),
    .i_octet(i_tx_octet),
    .i_octet_is_k(i_tx_octet_is_k),
    .i_frame_end_slot(i_frame_end_slot),
    .i_ident_slot(i_ident_slot),
    .o_octet(o_tx_octet),
    .o_octet_is_k(o_tx_octet_is_k)
  );

  assign o_rdata = st_r.rdata;
  assign o_serial_link_enable = st_r.link_ctrl[CTRL_LINK_EN_BIT];
  assign o_link_8b10b = st_r.link_ctrl[CTRL_8B10B_BIT];
  assign o_link_device_ident = st_r.device_ident;
  assign o_frame_end_comma_select = st_r.frame_end[FRAME_END_SEL_MSB:FRAME_END_SEL_LSB];
  assign o_channel_enable = st_r.ch_on;
  assign o_conv_count = st_r.conv_cnt;
  assign o_lane_count = st_r.lane_cnt;
  assign o_tail_pad = st_r.tail_pad;

endmodule : jesd_link_config_status

// >>> bench/jesd_link_config_status_properties.sv
// Port-level checks for the link configuration and status slice
`timescale 1ns/1ps
module jesd_link_config_status_properties
  import link_cfg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [9:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_link_up,
  input wire logic i_sync_n_pin,
  input wire logic i_ser_pll_lock,
  input wire logic i_conv_pll_lock,
  input wire logic i_sysref_realign,
  input wire logic i_sysref_event,
  input wire logic [7:0] i_tx_octet,
  input wire logic i_tx_octet_is_k,
  input wire logic i_frame_end_slot,
  input wire logic i_ident_slot,
  input wire logic [7:0] o_tx_octet,
  input wire logic o_tx_octet_is_k,
  input wire logic o_link_8b10b,
  input wire logic [7:0] o_link_device_ident,
  input wire logic [1:0] o_frame_end_comma_select,
  input wire logic [3:0] o_channel_enable
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Cycles since reset; SYNC~ and lock bits pass two sync stages, so early reads are skipped
  logic [2:0] age_r;
  logic [2:0] age_nxt;
  wire st_rd = i_rd && i_addr == ADDR_STATUS;
  wire fe = i_frame_end_slot && !i_ident_slot;
  always_comb age_nxt = i_rst ? 3'h0 : (age_r == 3'h7 ? age_r : age_r + 3'h1);
  always_ff @(posedge i_mclk) age_r <= age_nxt;
  function automatic logic [7:0] comma_of(input logic [1:0] s);
    return s == 2'h1 ? K28_1_CODE : (s == 2'h2 ? K28_5_CODE : K28_7_CODE);
  endfunction : comma_of
  property p_live(logic pin, int b);
    st_rd && age_r == 3'h7 && $past(pin) == pin && $past(pin, 2) == pin && $past(pin, 3) == pin
      |=> o_rdata[b] == $past(pin);
  endproperty
  AST_IDENT_SLOT: assert property (i_ident_slot |=>
    o_tx_octet == $past(o_link_device_ident) && !o_tx_octet_is_k) else $error("ident slot");
  AST_COMMA_CODE: assert property (fe && o_link_8b10b && o_frame_end_comma_select != 2'h3
    |=> o_tx_octet == comma_of($past(o_frame_end_comma_select)) && o_tx_octet_is_k)
    else $error("comma code");
  AST_NO_COMMA: assert property (fe && !o_link_8b10b |=> o_tx_octet == $past(i_tx_octet)
    && o_tx_octet_is_k == $past(i_tx_octet_is_k)) else $error("comma outside 8b10b");
  AST_LINK_UP: assert property (p_live(i_link_up, 6)) else $error("link up bit");
  AST_SYNC_LEVEL: assert property (p_live(i_sync_n_pin, 5)) else $error("sync bit");
  AST_SER_LOCK: assert property (p_live(i_ser_pll_lock, 2)) else $error("ser lock");
  AST_CONV_LOCK: assert property (p_live(i_conv_pll_lock, 0)) else $error("conv lock");
  AST_REALIGN_SET: assert property (i_sysref_realign ##1 st_rd |=> o_rdata[4])
    else $error("realign flag");
  AST_PHASE_CLR: assert property (i_wr && i_addr == ADDR_STATUS && i_wdata[3] &&
    !i_sysref_event ##1 !i_sysref_event ##1 st_rd |=> !o_rdata[3]) else $error("phase clear");
  AST_ONE_CHANNEL: assert property (i_wr && i_addr == ADDR_CHAN_EN && i_wdata[2]
    ##1 !i_wr |=> o_channel_enable == 4'h1) else $error("one channel");
  cover property (i_ident_slot);
  cover property (st_rd ##1 o_rdata[3]);
  cover property (fe && o_link_8b10b);
endmodule : jesd_link_config_status_properties

// >>> bench/link_receiver_model.sv
// Far-end receiver: holds SYNC~ low until four K28.5 code groups in a row
`timescale 1ns/1ps
module link_receiver_model
  import link_cfg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_octet,
  input wire logic i_octet_is_k,
  input wire logic i_resync,
  output logic o_sync_n
);
  logic [1:0] run_r;
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_resync) begin
      run_r <= 2'h0;
      o_sync_n <= 1'b0;
    end else if (i_octet_is_k && i_octet == K28_5_CODE) begin
      run_r <= run_r + 2'h1;
      if (run_r == 2'h3) o_sync_n <= 1'b1;
    end else if (!o_sync_n) begin
      run_r <= 2'h0;
    end
  end
endmodule : link_receiver_model

// >>> bench/jesd_link_config_status_bench.sv
// Self-checking bench for the link configuration and status slice
`timescale 1ns/1ps
module jesd_link_config_status_bench;
  import link_cfg_pkg::*;
  logic mclk = 0, rst = 1, wr = 0, rd = 0, link_up = 0, ser_lock = 0, conv_lock = 0;
  logic realign = 0, sref_ev = 0, fe = 0, id = 0, octet_k = 0, resync = 0;
  logic sync_n, tx_k, tail, link_en_o, b8_o;
  logic [1:0] csel_o;
  logic [9:0] addr = 10'h0;
  logic [7:0] wdata = 8'h0, octet = 8'h0, rdata, tx_o, ident, d, dev_id_o;
  logic [4:0] fconv = 5'h8, conv;
  logic [3:0] flane = 4'h4, lane, chen;
  logic [7:0] ch_tab[4] = '{8'h01, 8'h02, 8'h05, 8'h03};
  logic [7:0] ch_exp[4] = '{8'h03, 8'h0c, 8'h01, 8'h0f};
  int fails = 0, n_tests = 0;
  bit red;
  jesd_link_config_status dut_u (.i_mclk(mclk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_link_up(link_up), .i_sync_n_pin(sync_n),
    .i_ser_pll_lock(ser_lock), .i_conv_pll_lock(conv_lock), .i_sysref_realign(realign),
    .i_sysref_event(sref_ev), .i_full_conv_count(fconv), .i_full_lane_count(flane),
    .i_tx_octet(octet), .i_tx_octet_is_k(octet_k), .i_frame_end_slot(fe), .i_ident_slot(id),
    .o_tx_octet(tx_o), .o_tx_octet_is_k(tx_k), .o_serial_link_enable(link_en_o),
    .o_link_8b10b(b8_o), .o_link_device_ident(dev_id_o), .o_frame_end_comma_select(csel_o),
    .o_channel_enable(chen),
    .o_conv_count(conv), .o_lane_count(lane), .o_tail_pad(tail));
  link_receiver_model rx_u (.i_mclk(mclk), .i_rst(rst), .i_octet(tx_o), .i_octet_is_k(tx_k),
    .i_resync(resync), .o_sync_n(sync_n));
  initial forever #2.5 mclk = ~mclk;
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Strobe tasks also end any one-cycle SYSREF pulse raised just before them
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] v);
    @(posedge mclk) begin wr <= 1'b1; addr <= a; wdata <= v; realign <= 1'b0; sref_ev <= 1'b0; end
    @(posedge mclk) wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
    @(posedge mclk) begin rd <= 1'b1; addr <= a; realign <= 1'b0; sref_ev <= 1'b0; end
    @(posedge mclk) rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd_chk
  task automatic tx(input logic f, input logic i, input logic [7:0] v, input logic k,
                    input logic [7:0] eo, input logic ek);
    @(posedge mclk) begin fe <= f; id <= i; octet <= v; octet_k <= k; end
    @(posedge mclk) begin fe <= 1'b0; id <= 1'b0; octet_k <= 1'b0; end
    #1 chk(tx_o, eo);
    chk({7'h0, tx_k}, {7'h0, ek});
  endtask : tx
  function automatic logic [7:0] fe_exp(input logic [1:0] s, input logic [7:0] v);
    return s == 2'h3 ? v : (s == 2'h0 ? K28_7_CODE : (s == 2'h1 ? K28_1_CODE : K28_5_CODE));
  endfunction : fe_exp
  initial begin
    void'($urandom(32'hadd31526));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd_chk(ADDR_DEVICE_IDENT, RST_DEVICE_IDENT);
    rd_chk(ADDR_FRAME_END, RST_FRAME_END);
    rd_chk(ADDR_CHAN_EN, 8'h03);
    chk({4'h0, chen}, 8'h0f);
    rd_chk(10'h3ff, UNMAPPED_READ);
    $display("reset values done");
    ident = 8'($urandom);
    wr_reg(ADDR_DEVICE_IDENT, ident);
    rd_chk(ADDR_DEVICE_IDENT, ident);
    chk(dev_id_o, ident);
    wr_reg(ADDR_LINK_CTRL, 8'h02);
    for (int s = 0; s < 4; s++) begin
      wr_reg(ADDR_FRAME_END, {6'h0, 2'(s)});
      d = 8'($urandom);
      tx(1'b1, 1'b0, d, 1'b0, fe_exp(2'(s), d), s != 3);
      chk({6'h0, csel_o}, {6'h0, 2'(s)});
    end
    // The far end is a generic 8B/10B receiver, so K28.5 avoids false commas
    wr_reg(ADDR_FRAME_END, 8'h02);
    tx(1'b1, 1'b1, d, 1'b1, ident, 1'b0);
    wr_reg(ADDR_LINK_CTRL, 8'h00);
    tx(1'b1, 1'b0, d, 1'b0, d, 1'b0);
    $display("transmit path done");
    @(posedge mclk) begin link_up <= 1'b1; ser_lock <= 1'b1; conv_lock <= 1'b1; end
    repeat (8) @(posedge mclk);
    rd_chk(ADDR_STATUS, 8'h45);
    // The receiver wants four K28.5 groups back to back, so no gap between them
    @(posedge mclk) begin octet <= K28_5_CODE; octet_k <= 1'b1; end
    repeat (4) begin
      @(posedge mclk) #1;
      chk(tx_o, K28_5_CODE);
      chk({7'h0, tx_k}, 8'h01);
    end
    @(posedge mclk) octet_k <= 1'b0;
    repeat (8) @(posedge mclk);
    rd_chk(ADDR_STATUS, 8'h65);
    wr_reg(ADDR_LINK_CTRL, 8'h03);
    @(posedge mclk) begin sref_ev <= 1'b1; realign <= 1'b1; end
    rd_chk(ADDR_STATUS, 8'h7d);
    chk({6'h0, b8_o, link_en_o}, 8'h03);
    wr_reg(ADDR_STATUS, 8'hff);
    rd_chk(ADDR_STATUS, 8'h65);
    @(posedge mclk) resync <= 1'b1;
    @(posedge mclk) resync <= 1'b0;
    repeat (8) @(posedge mclk);
    rd_chk(ADDR_STATUS, 8'h45);
    $display("status done");
    wr_reg(ADDR_LINK_CTRL, 8'h00);
    fconv <= 5'($urandom_range(16, 1));
    flane <= 4'($urandom_range(8, 1));
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_CHAN_EN, ch_tab[i]);
      @(posedge mclk) #1;
      red = i < 3;
      chk({4'h0, chen}, ch_exp[i]);
      chk({3'h0, conv}, red ? {4'h0, fconv[4:1]} : {3'h0, fconv});
      chk({4'h0, lane}, red ? 8'((flane + 5'h1) >> 1) : {4'h0, flane});
      chk({7'h0, tail}, {7'h0, red & flane[0]});
    end
    chk({6'h0, b8_o, link_en_o}, 8'h00);
    $display("channel geometry done");
    test_done();
  end
  initial begin
    #(5ns * 4000);
    fails++;
    test_done();
  end
endmodule : jesd_link_config_status_bench
bind jesd_link_config_status jesd_link_config_status_properties props_u (.*);
